// *** core/codec_regs_pkg.sv ***
// package: register map, field positions and reset values of the codec control slice
// assumes: a 4-bit register index and 16-bit register words from the frame decoder
`default_nettype none
package codec_regs_pkg;
   // *****************************************************
   // register indices
   // *****************************************************
   localparam int          ADDR_W      = 4;
   localparam int          DATA_W      = 16;
   localparam logic [3:0]  ADDR_INT    = 4'h4;
   localparam logic [3:0]  ADDR_TEL_A  = 4'h5;
   localparam logic [3:0]  ADDR_TEL_B  = 4'h6;
   localparam logic [3:0]  ADDR_AUD_A  = 4'h7;
   localparam logic [3:0]  ADDR_AUD_B  = 4'h8;
   localparam logic [3:0]  ADDR_PANEL  = 4'h9;
   // *****************************************************
   // field positions
   // *****************************************************
   localparam int          TCLIP_IRQ_BIT = 14;
   localparam int          ACLIP_IRQ_BIT = 15;
   localparam int          DIV_LSB       = 0;
   localparam int          DIV_MSB       = 6;
   localparam int          TELECOM_LOOPBACK_BIT  = 7;
   localparam int          TEL_VOICE_BIT = 3;
   localparam int          TEL_CLIP_BIT  = 4;
   localparam int          TELECOM_INPUT_ATTENUATE_BIT   = 6;
   localparam int          TEL_SIDE_BIT  = 11;
   localparam int          MUTE_BIT      = 13;
   localparam int          IN_ON_BIT     = 14;
   localparam int          OUT_ON_BIT    = 15;
   localparam int          GAIN_LSB      = 7;
   localparam int          GAIN_MSB      = 11;
   localparam int          ATT_LSB       = 0;
   localparam int          ATT_MSB       = 4;
   localparam int          AUD_CLIP_BIT  = 6;
   localparam int          AUDIO_LOOPBACK_BIT  = 8;
   localparam int          POW_LSB       = 0;
   localparam int          POW_MSB       = 3;
   localparam int          XM_GND_BIT    = 4;
   // *****************************************************
   // writable bits and reset values
   // *****************************************************
   localparam logic [15:0] TEL_A_MASK  = 16'h00ff;
   localparam logic [15:0] TEL_B_MASK  = 16'he848;
   localparam logic [15:0] AUD_A_MASK  = 16'h0fff;
   localparam logic [15:0] AUD_B_MASK  = 16'he11f;
   localparam logic [15:0] PANEL_MASK  = 16'h001f;
   localparam logic [15:0] TEL_A_RST   = 16'h0010;
   localparam logic [15:0] AUD_A_RST   = 16'h0006;
   localparam logic [15:0] ZERO_WORD   = 16'h0000;
endpackage : codec_regs_pkg
`default_nettype wire

// *** core/codec_touch_control_regs.sv ***
// control and status registers for the telecom codec, audio codec and panel drive
// assumes: the serial frame decoder delivers one-cycle read/write strobes on clock_in;
// clip inputs come from the analog side and are asynchronous
//
// Summary of operation
// [R1] rising write of bit 14 clears telecom interrupt
// [R2] rising write of bit 15 clears audio interrupt
// [R3] status read: telecom bit 14, audio bit 15
// [R4] telecom divisor bits 0-6, resets to 16
// [R5] telecom B bit 3 enables voice-band filter
// [R6] telecom clip status reads, sticky until cleared
// [R7] rising write of bit 4 clears telecom clip
// [R8] telecom B bit 6 enables 6 dB attenuation
// [R9] telecom B bit 11 enables sidetone suppression
// [R10] telecom B bit 13 mutes telecom output
// [R11] bits 14/15 activate telecom input/output paths
// [R12] audio divisor bits 0-6, resets to 6
// [R13] audio A bits 7-11 set input gain
// [R14] audio B bits 0-4 set output attenuation
// [R15] audio clip status reads, sticky until cleared
// [R16] rising write of bit 6 clears audio clip
// [R17] audio B bit 8 enables audio loopback
// [R18] audio B bit 13 mutes audio output
// [R19] bits 14/15 activate audio input/output paths
// [R20] panel bits 0-3 power the four electrodes
// [R21] panel bit 4 grounds x-minus electrode
// [R22] enabled clip edges set interrupt status
// [R23] clears need a written 0-to-1 change
// [R24] undefined bits read zero, ignore writes
`default_nettype none
module codec_touch_control_regs
   import codec_regs_pkg::*;
(
   input  wire logic              clock_in,
   input  wire logic              arst_n_in,
   input  wire logic              reg_write_in,
   input  wire logic              reg_read_in,
   input  wire logic [ADDR_W-1:0] reg_addr_in,
   input  wire logic [DATA_W-1:0] reg_wdata_in,
   output logic      [DATA_W-1:0] reg_rdata_out,
   output logic                   reg_rvalid_out,
   input  wire logic              telecom_clip_in,
   input  wire logic              audio_clip_in,
   input  wire logic              telecom_clip_rise_enable_in,
   input  wire logic              telecom_clip_fall_enable_in,
   input  wire logic              audio_clip_rise_enable_in,
   input  wire logic              audio_clip_fall_enable_in,
   output logic                   telecom_clip_irq_status_out,
   output logic                   audio_clip_irq_status_out,
   output logic      [6:0]        telecom_rate_divisor_out,
   output logic                   telecom_loopback_out,
   output logic                   telecom_voiceband_filter_on_out,
   output logic                   telecom_input_attenuate_out,
   output logic                   sidetone_suppress_on_out,
   output logic                   telecom_output_silence_out,
   output logic                   telecom_input_path_on_out,
   output logic                   telecom_output_path_on_out,
   output logic      [6:0]        audio_rate_divisor_out,
   output logic      [4:0]        audio_input_gain_out,
   output logic      [4:0]        audio_output_attenuation_out,
   output logic                   audio_loopback_out,
   output logic                   audio_output_silence_out,
   output logic                   audio_input_path_on_out,
   output logic                   audio_output_path_on_out,
   output logic      [3:0]        panel_power_out,
   output logic                   panel_x_minus_ground_out
);
   // *****************************************************
   // reset release
   // *****************************************************
   logic       rst_meta;
   logic       rst_n;

   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // *****************************************************
   // write decode
   // *****************************************************
   function automatic logic hit(input logic we, input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
      hit = we && (a == r);
   endfunction : hit

   wire wr_int   = hit(reg_write_in, reg_addr_in, ADDR_INT);
   wire wr_tel_a = hit(reg_write_in, reg_addr_in, ADDR_TEL_A);
   wire wr_tel_b = hit(reg_write_in, reg_addr_in, ADDR_TEL_B);
   wire wr_aud_a = hit(reg_write_in, reg_addr_in, ADDR_AUD_A);
   wire wr_aud_b = hit(reg_write_in, reg_addr_in, ADDR_AUD_B);
   wire wr_panel = hit(reg_write_in, reg_addr_in, ADDR_PANEL);

   logic [DATA_W-1:0] tel_a;
   logic [DATA_W-1:0] tel_b;
   logic [DATA_W-1:0] aud_a;
   logic [DATA_W-1:0] aud_b;
   logic [DATA_W-1:0] panel;

   // only defined bits are stored, so undefined ones read back zero
   always_ff @(posedge clock_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tel_a <= TEL_A_RST;                                   // [R4]
         tel_b <= ZERO_WORD;
         aud_a <= AUD_A_RST;                                   // [R12]
         aud_b <= ZERO_WORD;
         panel <= ZERO_WORD;
      end
      else
      begin
         if (wr_tel_a) tel_a <= reg_wdata_in & TEL_A_MASK;     // [R4] [R24]
         if (wr_tel_b) tel_b <= reg_wdata_in & TEL_B_MASK;     // [R24]
         if (wr_aud_a) aud_a <= reg_wdata_in & AUD_A_MASK;     // [R12]
         if (wr_aud_b) aud_b <= reg_wdata_in & AUD_B_MASK;
         if (wr_panel) panel <= reg_wdata_in & PANEL_MASK;
      end
   end

   // *****************************************************
   // clip channels: index 0 telecom, 1 audio
   // *****************************************************
   logic [1:0] clip_meta;
   logic [1:0] clip_sync;
   logic [1:0] clip_prev;
   logic [1:0] irq_status;
   logic [1:0] irq_last;
   logic [1:0] det_status;
   logic [1:0] det_last;
   logic [1:0] irq_set;
   logic [1:0] irq_clr;
   logic [1:0] det_clr;
   logic [1:0] irq_wbit;
   logic [1:0] det_wbit;
   logic [1:0] det_wr;

   wire [1:0] clip_raw = {audio_clip_in, telecom_clip_in};
   wire [1:0] rise_en  = {audio_clip_rise_enable_in, telecom_clip_rise_enable_in};
   wire [1:0] fall_en  = {audio_clip_fall_enable_in, telecom_clip_fall_enable_in};

   assign irq_wbit = {reg_wdata_in[ACLIP_IRQ_BIT], reg_wdata_in[TCLIP_IRQ_BIT]};
   assign det_wbit = {reg_wdata_in[AUD_CLIP_BIT], reg_wdata_in[TEL_CLIP_BIT]};
   assign det_wr   = {wr_aud_b, wr_tel_b};

   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_chan
         assign irq_set[g] = (clip_sync[g] & ~clip_prev[g] & rise_en[g])
                           | (~clip_sync[g] & clip_prev[g] & fall_en[g]); // [R22]
         assign irq_clr[g] = wr_int & irq_wbit[g] & ~irq_last[g];         // [R1] [R2] [R23]
         assign det_clr[g] = det_wr[g] & det_wbit[g] & ~det_last[g];      // [R7] [R16] [R23]
      end
   endgenerate

   // an event landing on the clear cycle wins, so no clip is lost
   always_ff @(posedge clock_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         clip_meta  <= 2'h0;
         clip_sync  <= 2'h0;
         clip_prev  <= 2'h0;
         irq_status <= 2'h0;
         irq_last   <= 2'h0;
         det_status <= 2'h0;
         det_last   <= 2'h0;
      end
      else
      begin
         clip_meta  <= clip_raw;
         clip_sync  <= clip_meta;
         clip_prev  <= clip_sync;
         irq_status <= irq_set | (irq_status & ~irq_clr);      // [R22]
         det_status <= clip_sync | (det_status & ~det_clr);    // [R6] [R15]
         if (wr_int) irq_last <= irq_wbit;                     // [R23]
         for (int i = 0; i < 2; i++)
         begin
            if (det_wr[i]) det_last[i] <= det_wbit[i];         // [R23]
         end
      end
   end

   // *****************************************************
   // read path
   // *****************************************************
   logic [DATA_W-1:0] int_word;
   logic [DATA_W-1:0] tel_b_word;
   logic [DATA_W-1:0] aud_b_word;
   logic [DATA_W-1:0] read_word;

   always_comb
   begin
      int_word                   = ZERO_WORD;
      int_word[TCLIP_IRQ_BIT]    = irq_status[0];              // [R3]
      int_word[ACLIP_IRQ_BIT]    = irq_status[1];              // [R3]
      tel_b_word                 = tel_b;
      tel_b_word[TEL_CLIP_BIT]   = det_status[0];              // [R6]
      aud_b_word                 = aud_b;
      aud_b_word[AUD_CLIP_BIT]   = det_status[1];              // [R15]
   end

   assign read_word = (reg_addr_in == ADDR_INT)   ? int_word   :
                      (reg_addr_in == ADDR_TEL_A) ? tel_a      :
                      (reg_addr_in == ADDR_TEL_B) ? tel_b_word :
                      (reg_addr_in == ADDR_AUD_A) ? aud_a      :
                      (reg_addr_in == ADDR_AUD_B) ? aud_b_word :
                      (reg_addr_in == ADDR_PANEL) ? panel      : ZERO_WORD; // [R24]

   // read data is held until the next read so the frame encoder may take it late
   always_ff @(posedge clock_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         reg_rdata_out  <= ZERO_WORD;
         reg_rvalid_out <= 1'b0;
      end
      else
      begin
         reg_rvalid_out <= reg_read_in;
         if (reg_read_in) reg_rdata_out <= read_word;
      end
   end

   // *****************************************************
   // control outputs
   // *****************************************************
   assign telecom_clip_irq_status_out     = irq_status[0];
   assign audio_clip_irq_status_out       = irq_status[1];
   assign telecom_rate_divisor_out        = tel_a[DIV_MSB:DIV_LSB];   // [R4]
   assign telecom_loopback_out            = tel_a[TELECOM_LOOPBACK_BIT];
   assign telecom_voiceband_filter_on_out = tel_b[TEL_VOICE_BIT];     // [R5]
   assign telecom_input_attenuate_out     = tel_b[TELECOM_INPUT_ATTENUATE_BIT];       // [R8]
   assign sidetone_suppress_on_out        = tel_b[TEL_SIDE_BIT];      // [R9]
   assign telecom_output_silence_out      = tel_b[MUTE_BIT];          // [R10]
   assign telecom_input_path_on_out       = tel_b[IN_ON_BIT];         // [R11]
   assign telecom_output_path_on_out      = tel_b[OUT_ON_BIT];        // [R11]
   assign audio_rate_divisor_out          = aud_a[DIV_MSB:DIV_LSB];   // [R12]
   assign audio_input_gain_out            = aud_a[GAIN_MSB:GAIN_LSB]; // [R13]
   assign audio_output_attenuation_out    = aud_b[ATT_MSB:ATT_LSB];   // [R14]
   assign audio_loopback_out              = aud_b[AUDIO_LOOPBACK_BIT];      // [R17]
   assign audio_output_silence_out        = aud_b[MUTE_BIT];          // [R18]
   assign audio_input_path_on_out         = aud_b[IN_ON_BIT];         // [R19]
   assign audio_output_path_on_out        = aud_b[OUT_ON_BIT];        // [R19]
   assign panel_power_out                 = panel[POW_MSB:POW_LSB];   // [R20]
   assign panel_x_minus_ground_out        = panel[XM_GND_BIT];        // [R21]

   // *****************************************************
   // assertions
   // *****************************************************
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_n);

   tel_irq_clear_a: assert property (irq_clr[0] && !irq_set[0] |=> !telecom_clip_irq_status_out) // [R1]
      else $error("telecom clip interrupt not cleared");
   aud_irq_clear_a: assert property (irq_clr[1] && !irq_set[1] |=> !audio_clip_irq_status_out) // [R2]
      else $error("audio clip interrupt not cleared");
   irq_read_a: assert property (reg_read_in && reg_addr_in == ADDR_INT |=> // [R3]
      reg_rvalid_out && reg_rdata_out[TCLIP_IRQ_BIT] == $past(irq_status[0])
      && reg_rdata_out[ACLIP_IRQ_BIT] == $past(irq_status[1]))
      else $error("interrupt status read mismatch");
   irq_edge_set_a: assert property (clip_sync[0] && !clip_prev[0] && telecom_clip_rise_enable_in // [R22]
      |=> telecom_clip_irq_status_out)
      else $error("enabled rising clip edge missed");
   irq_no_reclear_a: assert property (wr_int && reg_wdata_in[TCLIP_IRQ_BIT] && irq_last[0] // [R23]
      && irq_status[0] |=> irq_status[0])
      else $error("repeated one cleared telecom interrupt");
   det_sticky_a: assert property (det_status[1] && !det_clr[1] |=> // [R15]
      det_status[1])
      else $error("audio clip status dropped");
   det_clear_a: assert property (det_clr[0] && !clip_sync[0] |=> !det_status[0]) // [R7]
      else $error("telecom clip status not cleared");
   tel_b_write_a: assert property (wr_tel_b |=> // [R5]
      telecom_voiceband_filter_on_out == $past(reg_wdata_in[TEL_VOICE_BIT])
      && telecom_output_silence_out == $past(reg_wdata_in[MUTE_BIT]))
      else $error("telecom control B not stored");
   div_write_a: assert property (wr_aud_a |=> // [R12]
      audio_rate_divisor_out == $past(reg_wdata_in[DIV_MSB:DIV_LSB]))
      else $error("audio divisor not stored");
   unmapped_read_a: assert property (reg_read_in && (reg_addr_in < ADDR_INT || reg_addr_in > ADDR_PANEL) // [R24]
      |=> reg_rdata_out == ZERO_WORD)
      else $error("unmapped read not zero");

   irq_set_c: cover property (irq_set[1] ##1 audio_clip_irq_status_out);
   irq_clear_c: cover property (irq_status[0] ##1 irq_clr[0] ##1 !irq_status[0]);
   det_clear_c: cover property (det_clr[1] && !clip_sync[1]);
   set_wins_c: cover property (irq_set[0] && irq_clr[0]);
endmodule : codec_touch_control_regs
`default_nettype wire

// *** tb/frame_ctrl_model.sv ***
// model: system controller issuing decoded frame register accesses
// assumes: design samples the strobes on the rising edge of clock_in
`default_nettype none
module frame_ctrl_model
   import codec_regs_pkg::*;
(
   input  wire logic              clock_in,
   output logic                   reg_write_out,
   output logic                   reg_read_out,
   output logic      [ADDR_W-1:0] reg_addr_out,
   output logic      [DATA_W-1:0] reg_wdata_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      reg_write_out = 1'b0;
      reg_read_out  = 1'b0;
      reg_addr_out  = 4'h0;
      reg_wdata_out = 16'h0000;
   end
   // released lines show inverted values so a stale word never looks valid
   task automatic access(input logic wr, input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
      @(negedge clock_in);
      reg_write_out = wr;
      reg_read_out  = ~wr;
      reg_addr_out  = addr;
      reg_wdata_out = data;
      @(negedge clock_in);
      reg_write_out = 1'b0;
      reg_read_out  = 1'b0;
      reg_addr_out  = ~addr;
      reg_wdata_out = ~data;
   endtask : access
endmodule : frame_ctrl_model
`default_nettype wire

// *** tb/codec_touch_control_regs_tb.sv ***
// testbench: register slice driven through the controller model, reads checked from a queue
// assumes: design and package under core/, one 25 MHz clock
`default_nettype none
module codec_touch_control_regs_tb
   import codec_regs_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   logic             clock_in  = 1'b0;
   logic             arst_n_in = 1'b0;
   logic             reg_write, reg_read, reg_rvalid_out;
   logic [3:0]       reg_addr;
   logic [15:0]      reg_wdata, reg_rdata_out;
   logic [1:0]       clip      = 2'b00;
   logic [1:0]       rise_en   = 2'b01;
   logic [1:0]       fall_en   = 2'b10;
   logic [1:0]       irq;
   logic [6:0]       tdiv, adiv;
   logic [4:0]       gain, oatt;
   logic [3:0]       pow;
   logic             tloop, tvoice, tatt, tside, tmute, tin, tout, aloop, amute, ain, aout, xgnd;
   logic [15:0]      shadow [0:15];
   logic [15:0]      exp_q [$];
   wire  [15:0]      view [5:9];
   logic [15:0]      d;
   int               error_cnt = 0;
   int               checked   = 0;
   always #20 clock_in = ~clock_in;
   frame_ctrl_model i_ctrl (.clock_in(clock_in), .reg_write_out(reg_write), .reg_read_out(reg_read),
      .reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata));
   codec_touch_control_regs i_dut (.clock_in(clock_in), .arst_n_in(arst_n_in), .reg_write_in(reg_write),
      .reg_read_in(reg_read), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata_out),
      .reg_rvalid_out(reg_rvalid_out), .telecom_clip_in(clip[0]), .audio_clip_in(clip[1]),
      .telecom_clip_rise_enable_in(rise_en[0]), .telecom_clip_fall_enable_in(fall_en[0]),
      .audio_clip_rise_enable_in(rise_en[1]), .audio_clip_fall_enable_in(fall_en[1]),
      .telecom_clip_irq_status_out(irq[0]), .audio_clip_irq_status_out(irq[1]),
      .telecom_rate_divisor_out(tdiv), .telecom_loopback_out(tloop), .telecom_voiceband_filter_on_out(tvoice),
      .telecom_input_attenuate_out(tatt), .sidetone_suppress_on_out(tside), .telecom_output_silence_out(tmute),
      .telecom_input_path_on_out(tin), .telecom_output_path_on_out(tout), .audio_rate_divisor_out(adiv),
      .audio_input_gain_out(gain), .audio_output_attenuation_out(oatt), .audio_loopback_out(aloop),
      .audio_output_silence_out(amute), .audio_input_path_on_out(ain), .audio_output_path_on_out(aout),
      .panel_power_out(pow), .panel_x_minus_ground_out(xgnd));
   // *****************************************************
   // output levels rebuilt as register words
   // *****************************************************
   assign view[5] = {8'h00, tloop, tdiv};
   assign view[6] = {tout, tin, tmute, 1'b0, tside, 4'h0, tatt, 2'b00, tvoice, 3'b000};
   assign view[7] = {4'h0, gain, adiv};
   assign view[8] = {aout, ain, amute, 4'h0, aloop, 3'b000, oatt};
   assign view[9] = {11'h000, xgnd, pow};
   function automatic logic [15:0] mask_of(input logic [3:0] a);
      case (a)
         ADDR_TEL_A: return TEL_A_MASK;
         ADDR_TEL_B: return TEL_B_MASK;
         ADDR_AUD_A: return AUD_A_MASK;
         ADDR_AUD_B: return AUD_B_MASK;
         ADDR_PANEL: return PANEL_MASK;
         default:    return ZERO_WORD;
      endcase
   endfunction : mask_of
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      exp_q.push_back(exp);
      i_ctrl.access(1'b0, a, 16'($urandom()));
   endtask : rd
   task automatic wr(input logic [3:0] a, input logic [15:0] data);
      i_ctrl.access(1'b1, a, data);
      shadow[a] = data;
   endtask : wr
   task automatic check_views();
      for (int a = 5; a <= 9; a++)
         check(view[a], shadow[a] & mask_of(4'(a)));
   endtask : check_views
   task automatic read_all();
      for (int a = 0; a < 16; a++)
         rd(4'(a), shadow[a] & mask_of(4'(a)));
   endtask : read_all
   // *****************************************************
   // read results leave the queue in issue order
   // *****************************************************
   always @(negedge clock_in)
      if (reg_rvalid_out === 1'b1)
         check(reg_rdata_out, (exp_q.size() > 0) ? exp_q.pop_front() : 16'hxxxx);
   // telecom edges enabled on rise only, audio on fall only
   task automatic clip_case(input logic aud);
      logic [15:0] m;
      logic [15:0] dm;
      logic [3:0]  ra;
      m  = aud ? 16'h8000 : 16'h4000;
      dm = aud ? 16'h0040 : 16'h0010;
      ra = aud ? ADDR_AUD_B : ADDR_TEL_B;
      clip[aud] = 1'b1;
      repeat (8) @(negedge clock_in);
      // logical not keeps the flag one bit wide before the cast widens it
      check(16'(irq[aud]), 16'(!aud));
      rd(ADDR_INT, aud ? 16'h0000 : m);
      rd(ra, (shadow[ra] & mask_of(ra)) | dm);
      clip[aud] = 1'b0;
      repeat (8) @(negedge clock_in);
      check(16'(irq[aud]), 16'h0001);
      wr(ADDR_INT, 16'h0000);
      wr(ADDR_INT, m);
      check(16'(irq[aud]), 16'h0000);
      clip[aud] = 1'b1;
      repeat (8) @(negedge clock_in);
      clip[aud] = 1'b0;
      repeat (8) @(negedge clock_in);
      wr(ADDR_INT, m);
      check(16'(irq[aud]), 16'h0001);
      rd(ra, (shadow[ra] & mask_of(ra)) | dm);
      wr(ADDR_INT, 16'h0000);
      wr(ADDR_INT, m);
      check(16'(irq[aud]), 16'h0000);
      wr(ra, shadow[ra] & ~dm);
      wr(ra, shadow[ra] | dm);
      rd(ra, shadow[ra] & mask_of(ra));
      rd(ADDR_INT, 16'h0000);
   endtask : clip_case
   task automatic end_of_test();
      $display("counts: %0d compares, %0d mismatches", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_of_test
   // *****************************************************
   // main sequence
   // *****************************************************
   initial
   begin
      void'($urandom(72));
      foreach (shadow[i])
         shadow[i] = 16'h0000;
      shadow[ADDR_TEL_A] = TEL_A_RST;
      shadow[ADDR_AUD_A] = AUD_A_RST;
      repeat (12) @(posedge clock_in);
      @(negedge clock_in);
      arst_n_in = 1'b1;
      repeat (4) @(negedge clock_in);
      check_views();
      read_all();
      $display("test reset_values done");
      repeat (4)
      begin
         for (int a = 0; a < 16; a++)
         begin
            d = 16'($urandom());
            if (a == ADDR_TEL_A)
               d[6:0] = 7'(16 + $urandom_range(111));
            if (a == ADDR_AUD_A)
               d[6:0] = 7'(6 + $urandom_range(121));
            wr(4'(a), d);
         end
         check_views();
         read_all();
      end
      $display("test random_writes done");
      clip_case(1'b0);
      $display("test telecom_clip done");
      clip_case(1'b1);
      $display("test audio_clip done");
      repeat (4) @(negedge clock_in);
      check(16'(exp_q.size()), 16'h0000);
      end_of_test();
   end
   initial
   begin
      #(40 * 5000);
      error_cnt++;
      end_of_test();
   end
endmodule : codec_touch_control_regs_tb
`default_nettype wire
